// *** pcr_consts.vh ***
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH
`define PCR_CA_W 10
`define PCR_PKT_WORDS 3'd4
`define PCR_SUB_RESET 4'hF
`define PCR_ID_RESET 8'hFF
`define PCR_WR_OPCODE 5'h03
`define PCR_REG_ID 4'h0
`define PCR_REG_SUB 4'h1
`define PCR_REG_RATE 4'h2
`define PCR_REG_TEST 4'h3
`define PCR_REG_ORR 4'h4
`define PCR_REG_ORW 4'h5
`define PCR_REG_CRR 4'h6
`define PCR_REG_CRW 4'h7
`define PCR_RATE_RESET 8'h02
`define PCR_TEST_RESET 10'h000
`define PCR_LAT_RESET 8'h00
`define PCR_LAT_MAX 8'hFF
`define PCR_RATE_200 6'h02
`endif

// *** pcr_link_sampler.v ***
`include "pcr_consts.vh"
module pcr_link_sampler (
  input wire clk,
  input wire reset_n,
  input wire linkClk,
  input wire packetFlag,
  input wire [9:0] commandAddressBus,
  output reg wordStrobe,
  output reg wordFlag,
  output reg [9:0] wordData
);
  // two-stage sync on every pin; edge found on the second stage only
  reg [1:0] clkSync_q;
  reg [1:0] flagSync_q;
  reg [19:0] busSync_q;
  reg clkLast_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clkSync_q <= 2'h0;
      flagSync_q <= 2'h0;
      busSync_q <= 20'h00000;
      clkLast_q <= 1'b0;
      wordStrobe <= 1'b0;
      wordFlag <= 1'b0;
      wordData <= 10'h000;
    end else begin
      clkSync_q <= {clkSync_q[0], linkClk};
      flagSync_q <= {flagSync_q[0], packetFlag};
      busSync_q <= {busSync_q[9:0], commandAddressBus};
      clkLast_q <= clkSync_q[1];
      // rising edge of the link clock: capture one word
      wordStrobe <= clkSync_q[1] & ~clkLast_q;
      if (clkSync_q[1] & ~clkLast_q) begin
        wordFlag <= flagSync_q[1];
        wordData <= busSync_q[19:10];
      end
    end
  end
endmodule

// *** pcr_register_bank.v ***
`include "pcr_consts.vh"
// Functional notes
// R1: sub-address resets to fifteen
// R2: controller gives unique sub-addresses
// R3: match sub-address for register writes
// R4: group bit accepts any sub-address
// R5: both group bits accept every device
// R6: store only four sub-address bits
// R7: primary group bit never stored
// R8: sub-address packet layout
// R9: general register-write packet layout
// R10: controller writes one-hot supported rate
// R11: rate field decoded one-hot
// R12: controller writes the 200 MHz pattern
// R13: controller avoids test register
// R14: open-row read latency register
// R15: open-row write latency register
// R16: closed-row read latency register
// R17: closed-row write latency register
// R18: controller keeps latencies within limits
// R19: fine read verniers adjust read latencies
// R20: controller may vary read latencies
// R21: latency in low eight bits
// R22: compare primary address first
// R23: don't-care bits written zero
// R24: flag marks first packet word only
// R25: reserved selects are ignored
// R26: update only after fourth word
module pcr_register_bank (
  input wire clk,
  input wire reset_n,
  input wire linkClk,
  input wire packetFlag,
  input wire [9:0] commandAddressBus,
  input wire [7:0] primaryDeviceAddress,
  input wire readVernierInc,
  input wire readVernierDec,
  output wire [3:0] groupSubAddress,
  output wire [7:0] clockRateSelect,
  output wire [5:0] clockRateOneHot,
  output wire clockRateIllegal,
  output wire [9:0] vendorTestControl,
  output wire [7:0] openRowReadLatency,
  output wire [7:0] openRowWriteLatency,
  output wire [7:0] closedRowReadLatency,
  output wire [7:0] closedRowWriteLatency,
  output wire [7:0] actualOpenRowReadLatency,
  output wire [7:0] actualClosedRowReadLatency,
  output wire regWriteDone
);
  wire wordStrobe;
  wire wordFlag;
  wire [9:0] wordData;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_MATCH = 2'h1;
  localparam [1:0] ST_SELECT = 2'h2;
  localparam [1:0] ST_DATA = 2'h3;
  reg [1:0] incSync_q;
  reg [1:0] decSync_q;
  reg incLast_q;
  reg decLast_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg selected_q;
  reg selected_d;
  reg [3:0] regSel_q;
  reg [3:0] regSel_d;
  reg [8:0] word0_q;
  reg [8:0] word0_d;
  reg [3:0] groupSubAddress_q;
  reg [3:0] groupSubAddress_d;
  reg [7:0] clockRateSelect_q;
  reg [7:0] clockRateSelect_d;
  reg [5:0] clockRateOneHot_q;
  reg [5:0] clockRateOneHot_d;
  reg clockRateIllegal_q;
  reg clockRateIllegal_d;
  reg [9:0] vendorTestControl_q;
  reg [9:0] vendorTestControl_d;
  reg [7:0] openRowReadLatency_q;
  reg [7:0] openRowReadLatency_d;
  reg [7:0] openRowWriteLatency_q;
  reg [7:0] openRowWriteLatency_d;
  reg [7:0] closedRowReadLatency_q;
  reg [7:0] closedRowReadLatency_d;
  reg [7:0] closedRowWriteLatency_q;
  reg [7:0] closedRowWriteLatency_d;
  reg [7:0] actualOpenRowReadLatency_q;
  reg [7:0] actualOpenRowReadLatency_d;
  reg [7:0] actualClosedRowReadLatency_q;
  reg [7:0] actualClosedRowReadLatency_d;
  reg regWriteDone_q;
  reg regWriteDone_d;

  pcr_link_sampler sampler (
    .clk(clk),
    .reset_n(reset_n),
    .linkClk(linkClk),
    .packetFlag(packetFlag),
    .commandAddressBus(commandAddressBus),
    .wordStrobe(wordStrobe),
    .wordFlag(wordFlag),
    .wordData(wordData)
  );

  // one-hot check; any other pattern is reserved or illegal
  function oneHot8;
    input [7:0] v;
    begin
      oneHot8 = (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
    end
  endfunction

  // saturating step keeps the adjusted delay inside 0..255
  function [7:0] stepLat;
    input [7:0] v;
    input up;
    input down;
    begin
      if (up && !down && v != `PCR_LAT_MAX)
        stepLat = v + 8'h01;
      else if (down && !up && v != 8'h00)
        stepLat = v - 8'h01;
      else
        stepLat = v;
    end
  endfunction

  wire primaryGroup = word0_q[8]; // R7
  wire primaryHit = (word0_q[7:0] == primaryDeviceAddress) | primaryGroup; // R22
  wire subGroup = wordData[4];
  wire subHit = (wordData[3:0] == groupSubAddress_q) | subGroup; // R3 R4
  wire broadcast = primaryGroup & subGroup; // R5
  wire isRegWrite = (wordData[9:5] == `PCR_WR_OPCODE); // R9
  wire selectClean = (wordData[9:7] == 3'h0) && (wordData[2:0] == 3'h0); // R8
  wire incPulse = incSync_q[1] & ~incLast_q;
  wire decPulse = decSync_q[1] & ~decLast_q;
  wire commit = wordStrobe && !wordFlag && state_q == ST_DATA && selected_q; // R26
  wire mappedSel = (regSel_q[3] == 1'b0) && (regSel_q != `PCR_REG_ID); // R25

  assign groupSubAddress = groupSubAddress_q;
  assign clockRateSelect = clockRateSelect_q;
  assign clockRateOneHot = clockRateOneHot_q;
  assign clockRateIllegal = clockRateIllegal_q;
  assign vendorTestControl = vendorTestControl_q;
  assign openRowReadLatency = openRowReadLatency_q;
  assign openRowWriteLatency = openRowWriteLatency_q;
  assign closedRowReadLatency = closedRowReadLatency_q;
  assign closedRowWriteLatency = closedRowWriteLatency_q;
  assign actualOpenRowReadLatency = actualOpenRowReadLatency_q;
  assign actualClosedRowReadLatency = actualClosedRowReadLatency_q;
  assign regWriteDone = regWriteDone_q;

  // vernier pins are async levels; edge found after the second flop
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      incSync_q <= 2'h0;
      decSync_q <= 2'h0;
      incLast_q <= 1'b0;
      decLast_q <= 1'b0;
    end else begin
      incSync_q <= {incSync_q[0], readVernierInc};
      decSync_q <= {decSync_q[0], readVernierDec};
      incLast_q <= incSync_q[1];
      decLast_q <= decSync_q[1];
    end
  end

  // word tracker; a new flag always restarts, even mid-packet
  always @* begin
    state_d = state_q;
    selected_d = selected_q;
    regSel_d = regSel_q;
    word0_d = word0_q;
    if (wordStrobe) begin
      if (wordFlag) begin // R24
        word0_d = wordData[9:1];
        selected_d = wordData[0]; // R9
        state_d = ST_MATCH;
      end else begin
        case (state_q)
          ST_IDLE: begin
            // flag low while idle is a no-op
            selected_d = 1'b0;
          end
          ST_MATCH: begin
            selected_d = selected_q & isRegWrite & ((primaryHit & subHit) | broadcast);
            state_d = ST_SELECT;
          end
          ST_SELECT: begin
            regSel_d = wordData[6:3]; // R8
            selected_d = selected_q & selectClean;
            state_d = ST_DATA;
          end
          ST_DATA: begin
            selected_d = 1'b0;
            state_d = ST_IDLE;
          end
          default: begin
            selected_d = 1'b0;
            state_d = ST_IDLE;
          end
        endcase
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      selected_q <= 1'b0;
      regSel_q <= 4'h0;
      word0_q <= 9'h000;
    end else begin
      state_q <= state_d;
      selected_q <= selected_d;
      regSel_q <= regSel_d;
      word0_q <= word0_d;
    end
  end

  // register next values; a commit wins over a vernier step in one cycle
  always @* begin
    groupSubAddress_d = groupSubAddress_q;
    clockRateSelect_d = clockRateSelect_q;
    clockRateOneHot_d = clockRateOneHot_q;
    clockRateIllegal_d = clockRateIllegal_q;
    vendorTestControl_d = vendorTestControl_q;
    openRowReadLatency_d = openRowReadLatency_q;
    openRowWriteLatency_d = openRowWriteLatency_q;
    closedRowReadLatency_d = closedRowReadLatency_q;
    closedRowWriteLatency_d = closedRowWriteLatency_q;
    actualOpenRowReadLatency_d = actualOpenRowReadLatency_q;
    actualClosedRowReadLatency_d = actualClosedRowReadLatency_q;
    regWriteDone_d = 1'b0;
    if (incPulse || decPulse) begin // R19
      actualOpenRowReadLatency_d = stepLat(actualOpenRowReadLatency_q, incPulse, decPulse);
      actualClosedRowReadLatency_d =
        stepLat(actualClosedRowReadLatency_q, incPulse, decPulse);
    end
    if (commit) begin
      regWriteDone_d = mappedSel; // R25
      case (regSel_q)
        `PCR_REG_SUB: begin
          groupSubAddress_d = wordData[3:0]; // R6 R8
        end
        `PCR_REG_RATE: begin // R11
          clockRateSelect_d = wordData[7:0];
          clockRateOneHot_d = oneHot8(wordData[7:0]) ? wordData[5:0] : 6'h00;
          clockRateIllegal_d = !oneHot8(wordData[7:0]) || (wordData[7:6] != 2'h0);
        end
        `PCR_REG_TEST: begin
          vendorTestControl_d = wordData;
        end
        `PCR_REG_ORR: begin // R14 R21
          openRowReadLatency_d = wordData[7:0];
          // a fresh write drops the vernier steps taken so far
          actualOpenRowReadLatency_d = wordData[7:0];
        end
        `PCR_REG_ORW: begin // R15 R21
          openRowWriteLatency_d = wordData[7:0];
        end
        `PCR_REG_CRR: begin // R16 R21
          closedRowReadLatency_d = wordData[7:0];
          actualClosedRowReadLatency_d = wordData[7:0];
        end
        `PCR_REG_CRW: begin // R17 R21
          closedRowWriteLatency_d = wordData[7:0];
        end
        default: begin
          // id lives outside this block; reserved selects leave all as is
          regWriteDone_d = 1'b0; // R25
        end
      endcase
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      groupSubAddress_q <= `PCR_SUB_RESET; // R1
      clockRateSelect_q <= `PCR_RATE_RESET;
      clockRateOneHot_q <= `PCR_RATE_200;
      clockRateIllegal_q <= 1'b0;
      vendorTestControl_q <= `PCR_TEST_RESET;
      openRowReadLatency_q <= `PCR_LAT_RESET;
      openRowWriteLatency_q <= `PCR_LAT_RESET;
      closedRowReadLatency_q <= `PCR_LAT_RESET;
      closedRowWriteLatency_q <= `PCR_LAT_RESET;
      actualOpenRowReadLatency_q <= `PCR_LAT_RESET;
      actualClosedRowReadLatency_q <= `PCR_LAT_RESET;
      regWriteDone_q <= 1'b0;
    end else begin
      groupSubAddress_q <= groupSubAddress_d;
      clockRateSelect_q <= clockRateSelect_d;
      clockRateOneHot_q <= clockRateOneHot_d;
      clockRateIllegal_q <= clockRateIllegal_d;
      vendorTestControl_q <= vendorTestControl_d;
      openRowReadLatency_q <= openRowReadLatency_d;
      openRowWriteLatency_q <= openRowWriteLatency_d;
      closedRowReadLatency_q <= closedRowReadLatency_d;
      closedRowWriteLatency_q <= closedRowWriteLatency_d;
      actualOpenRowReadLatency_q <= actualOpenRowReadLatency_d;
      actualClosedRowReadLatency_q <= actualClosedRowReadLatency_d;
      regWriteDone_q <= regWriteDone_d;
    end
  end
endmodule

// *** pcr_bank_props.sv ***
module pcr_bank_props (
  input wire clk,
  input wire reset_n,
  input wire linkClk,
  input wire readVernierInc,
  input wire readVernierDec,
  input wire [3:0] groupSubAddress,
  input wire [7:0] clockRateSelect,
  input wire [5:0] clockRateOneHot,
  input wire clockRateIllegal,
  input wire [9:0] vendorTestControl,
  input wire [7:0] openRowReadLatency,
  input wire [7:0] openRowWriteLatency,
  input wire [7:0] closedRowReadLatency,
  input wire [7:0] closedRowWriteLatency,
  input wire [7:0] actualOpenRowReadLatency,
  input wire regWriteDone
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // saturates so a stale commit long after traffic still fails
  reg [3:0] sinceRise_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) sinceRise_q <= 4'hF;
    else if ($rose(linkClk)) sinceRise_q <= 4'h0;
    else if (sinceRise_q != 4'hF) sinceRise_q <= sinceRise_q + 4'h1;
  end
  sequence sIncStep;
    $rose(readVernierInc) && !readVernierDec && actualOpenRowReadLatency != 8'hFF;
  endsequence
  sequence sDecStep;
    $rose(readVernierDec) && !readVernierInc && actualOpenRowReadLatency != 8'h00;
  endsequence
  a_sub_reset: assert property ($rose(reset_n) |-> groupSubAddress == 4'hF)
    else $error("sub-address not all ones");
  a_rate_decode: assert property (
    clockRateOneHot == (clockRateIllegal ? 6'h00 : clockRateSelect[5:0]))
    else $error("rate decode wrong");
  a_rate_illegal: assert property (
    clockRateIllegal == !($onehot(clockRateSelect[5:0]) && clockRateSelect[7:6] == 2'b00))
    else $error("rate legality wrong");
  a_write_commit: assert property (
    $changed({groupSubAddress, clockRateSelect, vendorTestControl, openRowReadLatency,
    openRowWriteLatency, closedRowReadLatency, closedRowWriteLatency}) |-> regWriteDone)
    else $error("register changed without commit");
  a_done_pulse: assert property (regWriteDone |=> !regWriteDone)
    else $error("commit pulse too long");
  a_done_timing: assert property (regWriteDone |-> sinceRise_q inside {[1:8]})
    else $error("commit not after a word");
  a_vernier_inc: assert property (
    sIncStep |-> ##[2:8] $changed(actualOpenRowReadLatency))
    else $error("increment ignored");
  a_vernier_dec: assert property (
    sDecStep |-> ##[2:8] $changed(actualOpenRowReadLatency))
    else $error("decrement ignored");
endmodule
bind pcr_register_bank pcr_bank_props i_props (.*);

// *** pcr_ctl_model.sv ***
module pcr_ctl_model (
  input wire clk,
  output logic linkClk,
  output logic packetFlag,
  output logic [9:0] commandAddressBus
);
  timeunit 1ns;
  timeprecision 1ps;
  // command clock stands still between packets
  initial begin
    linkClk = 1'b0;
    packetFlag = 1'b0;
    commandAddressBus = 10'h000;
  end
  task automatic sendWord(input logic flag, input logic [9:0] w);
    @(posedge clk);
    packetFlag <= flag;
    commandAddressBus <= w;
    repeat (3) @(posedge clk);
    linkClk <= 1'b1;
    repeat (4) @(posedge clk);
    linkClk <= 1'b0;
  endtask
  task automatic sendPacket(input logic [8:0] id, input logic [4:0] sub,
      input logic [3:0] sel, input logic [9:0] d);
    sendWord(1'b1, {id, 1'b1});
    sendWord(1'b0, {5'h03, sub});
    sendWord(1'b0, {3'h0, sel, 3'h0});
    sendWord(1'b0, d);
    // released bus shows the inverse, never a stale word
    @(posedge clk);
    packetFlag <= 1'b0;
    commandAddressBus <= ~commandAddressBus;
  endtask
endmodule

// *** tb_pcr_register_bank.sv ***
module tb_pcr_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic readVernierInc = 1'b0;
  logic readVernierDec = 1'b0;
  logic [7:0] primaryDeviceAddress = 8'h5A;
  wire linkClk, packetFlag, clockRateIllegal, regWriteDone;
  wire [9:0] commandAddressBus, vendorTestControl;
  wire [3:0] groupSubAddress;
  wire [5:0] clockRateOneHot;
  wire [7:0] clockRateSelect, openRowReadLatency, openRowWriteLatency, closedRowReadLatency;
  wire [7:0] closedRowWriteLatency, actualOpenRowReadLatency, actualClosedRowReadLatency;
  wire [31:0] lats = {openRowReadLatency, openRowWriteLatency, closedRowReadLatency,
    closedRowWriteLatency};
  int fail_count = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  pcr_register_bank i_dut (.*);
  pcr_ctl_model i_ctl (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // fixed settle time: a refused packet gives no completion to wait on
  task automatic wr(input logic [8:0] id, input logic [4:0] sub, input logic [3:0] sel,
      input logic [9:0] d);
    i_ctl.sendPacket(id, sub, sel, d);
    repeat (8) @(posedge clk);
  endtask
  task automatic pulse(input bit up);
    if (up) readVernierInc <= 1'b1;
    else readVernierDec <= 1'b1;
    repeat (6) @(posedge clk);
    readVernierInc <= 1'b0;
    readVernierDec <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    #100us;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(groupSubAddress, 4'hF);
    for (int s = 4; s < 8; s++) wr(9'h05A, 5'h0F, s[3:0], {2'b00, 8'hFF >> (s - 4)});
    check(lats, 32'hFF7F3F1F);
    for (int b = 0; b < 6; b++) begin
      wr(9'h05A, 5'h0F, 4'h2, 10'h001 << b);
      check(clockRateOneHot, 6'h01 << b);
    end
    wr(9'h05A, 5'h0F, 4'h2, 10'h003);
    check({clockRateIllegal, clockRateOneHot}, 7'h40);
    wr(9'h05A, 5'h0F, 4'h2, 10'h002);
    check({clockRateIllegal, clockRateSelect}, 9'h002);
    wr(9'h05A, 5'h0F, 4'h3, 10'h2A5);
    check(vendorTestControl, 10'h2A5);
    wr(9'h05A, 5'h0F, 4'h1, 10'h006);
    check(groupSubAddress, 4'h6);
    wr(9'h05A, 5'h03, 4'h4, 10'h011);
    check(openRowReadLatency, 8'hFF);
    wr(9'h05A, 5'h10, 4'h4, 10'h022);
    check(openRowReadLatency, 8'h22);
    wr(9'h011, 5'h16, 4'h4, 10'h033);
    check(openRowReadLatency, 8'h22);
    wr(9'h111, 5'h13, 4'h4, 10'h044);
    check(openRowReadLatency, 8'h44);
    wr(9'h1A5, 5'h1F, 4'h1, 10'h009);
    check(groupSubAddress, 4'h9);
    wr(9'h05A, 5'h09, 4'h8, 10'h055);
    check(lats, 32'h447F3F1F);
    pulse(1'b1);
    check({actualOpenRowReadLatency, actualClosedRowReadLatency}, 16'h4540);
    pulse(1'b0);
    check({actualOpenRowReadLatency, actualClosedRowReadLatency}, 16'h443F);
    i_ctl.sendWord(1'b1, 10'h0B4);
    i_ctl.sendWord(1'b0, 10'h069);
    i_ctl.sendWord(1'b0, 10'h020);
    i_ctl.sendWord(1'b0, 10'h077);
    repeat (8) @(posedge clk);
    check(openRowReadLatency, 8'h44);
    i_ctl.sendWord(1'b1, 10'h0B5);
    i_ctl.sendWord(1'b0, 10'h069);
    wr(9'h05A, 5'h09, 4'h5, 10'h012);
    check(openRowWriteLatency, 8'h12);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    check({groupSubAddress, clockRateSelect}, 12'hF02);
    check(lats, 32'h00000000);
    print_verdict();
  end
endmodule
